// ---- design/lua_pkg.sv ----
// constants and types for the central line unit activation block
package lua_pkg;
  // timer durations and derived counts
  localparam int unsigned CLK_HZ        = 250_000_000; // device clock rate
  localparam int unsigned TICK_MS       = 1;           // prescaler tick, ms
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned ACT_TIME_MS   = 30_000;  // activation timer
  localparam int unsigned ECHO_TIME_MS  = 5_000;   // echo hold timer
  localparam int unsigned PEND_TIME_MS  = 2_000;   // sync regain window
  localparam int unsigned SIGL_TIME_MS  = 1_000;   // signal loss window
  localparam int unsigned RDY_REPEAT    = 6;       // ready bit repeats
  localparam int unsigned SYNC_MISS_MAX = 5;       // intermediate states
  localparam int unsigned TW            = 16;      // ms counter width
  localparam int unsigned PW            = 28;      // prescaler width

  // transmitter content
  typedef enum logic [2:0] {
    LUA_TX_SILENT = 3'h0,
    LUA_TX_INIT   = 3'h1,
    LUA_TX_FRAMED = 3'h2,
    LUA_TX_DATA   = 3'h4
  } lua_tx_e;

  // activation states, one-hot
  typedef enum logic [6:0] {
    LUA_INACTIVE = 7'h01,
    LUA_ACTIVATE = 7'h02,
    LUA_RX_ACT   = 7'h04,
    LUA_TX_ACT   = 7'h08,
    LUA_FULL     = 7'h10,
    LUA_PEND     = 7'h20,
    LUA_DEACT    = 7'h40
  } lua_act_e;

  // sync states, one-hot
  typedef enum logic [3:0] {
    LUA_OOS   = 4'h1,
    LUA_FIRST = 4'h2,
    LUA_INS   = 4'h4,
    LUA_MISS  = 4'h8
  } lua_sync_e;
endpackage

// ---- design/lua_activation.sv ----
// central line unit activation and frame sync state machines
`timescale 1ns/1ps
`default_nettype none
module lua_activation #(
  parameter int unsigned PRESCALE = lua_pkg::TICK_CYC // cycles per tick
) (
  // clock and resets
  input  wire logic          i_ref_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_srst,
  // control
  input  wire logic          i_activation_request,
  input  wire logic          i_quiet_command,
  input  wire logic          i_sensitive_mode,
  // receive side indications
  input  wire logic          i_remote_power,
  input  wire logic          i_signal_loss,
  input  wire logic          i_frame_strobe,
  input  wire logic          i_sync_word_hit,
  input  wire logic          i_overhead_valid,
  input  wire logic          i_remote_ready_bit,
  // transmit side
  output logic [2:0]         o_tx_mode,
  output logic               o_central_ready_bit,
  // status
  output logic [6:0]         o_act_state,
  output logic               o_sync_word_loss,
  output logic               o_central_rx_ready,
  output logic               o_remote_rx_ready,
  output logic               o_sync_loss_timeout,
  output logic               o_signal_loss_timeout
);

  // whole state of the block
  typedef struct packed {
    lua_pkg::lua_act_e  act;       // activation state
    lua_pkg::lua_sync_e sync;      // sync state
    logic [2:0]         miss;      // miss count in intermediate states
    lua_pkg::lua_tx_e   tx;        // transmit content
    logic               echo_run;  // echo hold timer running
    logic               power_seen;// remote power seen this attempt
    logic               act_exp;   // activation timer expired
    logic [lua_pkg::PW-1:0] pre;   // prescaler
    logic [lua_pkg::TW-1:0] act_t; // activation timer, ms
    logic [lua_pkg::TW-1:0] aux_t; // echo, pending or loss timer, ms
    logic [2:0]         rdy_cnt;   // remote ready bit repeats
    logic               crx;       // central receiver ready
    logic               rrx;       // remote receiver ready
    logic               swl;       // sync word loss
    logic               slt;       // sync loss timeout
    logic               sgt;       // signal loss timeout
  } lua_state_s;

  lua_state_s st;       // registered state
  lua_state_s next_st;  // next value

  // reset value: inactive, silent, out of sync, nothing ready
  localparam lua_state_s RST = '{
    act: lua_pkg::LUA_INACTIVE, sync: lua_pkg::LUA_OOS, miss: 3'h0,
    tx: lua_pkg::LUA_TX_SILENT, echo_run: 1'b0, power_seen: 1'b0,
    act_exp: 1'b0, pre: '0, act_t: '0, aux_t: '0, rdy_cnt: 3'h0,
    crx: 1'b0, rrx: 1'b0, swl: 1'b1, slt: 1'b0, sgt: 1'b0};

  localparam logic [lua_pkg::TW-1:0] ACT_MS  = lua_pkg::TW'(lua_pkg::ACT_TIME_MS);
  localparam logic [lua_pkg::TW-1:0] ECHO_MS = lua_pkg::TW'(lua_pkg::ECHO_TIME_MS);
  localparam logic [lua_pkg::TW-1:0] PEND_MS = lua_pkg::TW'(lua_pkg::PEND_TIME_MS);
  localparam logic [lua_pkg::TW-1:0] SIGL_MS = lua_pkg::TW'(lua_pkg::SIGL_TIME_MS);
  localparam logic [lua_pkg::PW-1:0] PRE_TOP = lua_pkg::PW'(PRESCALE - 1);
  localparam logic [2:0] MISS_TOP = 3'(lua_pkg::SYNC_MISS_MAX);
  localparam logic [2:0] RDY_TOP  = 3'(lua_pkg::RDY_REPEAT);

  logic tick;     // one millisecond enable
  logic in_sync;  // sync machine holds frame alignment

  // next state logic for both machines
  always_comb begin
    next_st = st;
    // single prescaled tick drives every long timer
    tick = (st.pre == PRE_TOP);
    next_st.pre = tick ? '0 : st.pre + 1'b1;

    // frame sync machine: evaluated once per frame slot
    if (st.act == lua_pkg::LUA_INACTIVE || st.act == lua_pkg::LUA_DEACT) begin
      // no link: stay hunting, loss asserted
      next_st.sync = lua_pkg::LUA_OOS;
      next_st.miss = 3'h0;
    end else if (i_frame_strobe) begin
      case (st.sync)
        lua_pkg::LUA_OOS: begin
          if (i_sync_word_hit) next_st.sync = lua_pkg::LUA_FIRST;
        end
        lua_pkg::LUA_FIRST: begin
          // second hit in the next frame confirms alignment
          next_st.sync = i_sync_word_hit ? lua_pkg::LUA_INS
                                         : lua_pkg::LUA_OOS;
        end
        lua_pkg::LUA_INS: begin
          if (!i_sync_word_hit) begin
            next_st.sync = lua_pkg::LUA_MISS;
            next_st.miss = 3'h1;
          end
        end
        lua_pkg::LUA_MISS: begin
          if (i_sync_word_hit) begin
            next_st.sync = lua_pkg::LUA_INS;
            next_st.miss = 3'h0;
          end else if (st.miss == MISS_TOP) begin
            // sixth consecutive miss
            next_st.sync = lua_pkg::LUA_OOS;
            next_st.miss = 3'h0;
          end else begin
            next_st.miss = st.miss + 3'h1;
          end
        end
        default: next_st.sync = lua_pkg::LUA_OOS;
      endcase
    end
    in_sync = (next_st.sync == lua_pkg::LUA_INS)
           || (next_st.sync == lua_pkg::LUA_MISS);
    next_st.swl = !in_sync;

    // activation timer counts in ms while running
    if (tick && st.act_t != '0) next_st.act_t = st.act_t - 1'b1;
    if (st.act_t == 16'h0001 && tick) next_st.act_exp = 1'b1;
    if (tick && st.aux_t != '0) next_st.aux_t = st.aux_t - 1'b1;

    // remote ready bit counter: six zeros in a row
    if (i_overhead_valid) begin
      if (i_remote_ready_bit) next_st.rdy_cnt = 3'h0;
      else if (st.rdy_cnt != RDY_TOP) next_st.rdy_cnt = st.rdy_cnt + 3'h1;
    end
    if (next_st.rdy_cnt == RDY_TOP) next_st.rrx = 1'b1;

    // activation machine
    case (st.act)
      lua_pkg::LUA_INACTIVE: begin
        next_st.tx = lua_pkg::LUA_TX_SILENT;
        if (i_activation_request) begin
          next_st.act        = lua_pkg::LUA_ACTIVATE;
          next_st.tx         = lua_pkg::LUA_TX_INIT;
          next_st.act_t      = ACT_MS;
          next_st.act_exp    = 1'b0;
          next_st.power_seen = 1'b0;
          next_st.echo_run   = 1'b0;
          next_st.crx = 1'b0;
          next_st.rrx = 1'b0;
          next_st.rdy_cnt = 3'h0;
          next_st.slt = 1'b0;
          next_st.sgt = 1'b0;
        end
      end
      lua_pkg::LUA_ACTIVATE: begin
        if (i_remote_power && !st.power_seen) begin
          // remote power: hold initial training, restart timer
          next_st.power_seen = 1'b1;
          next_st.echo_run   = 1'b1;
          next_st.aux_t      = ECHO_MS;
          next_st.act_t      = ACT_MS;
        end else if (st.echo_run && st.aux_t == '0) begin
          next_st.echo_run = 1'b0;
          next_st.tx       = lua_pkg::LUA_TX_FRAMED;
        end
        if (st.act_exp && st.swl) begin
          next_st.swl = 1'b1;
          next_st.tx  = lua_pkg::LUA_TX_SILENT;
          next_st.act = lua_pkg::LUA_DEACT;
          next_st.aux_t = SIGL_MS;
        end else if (!st.swl && st.tx == lua_pkg::LUA_TX_FRAMED) begin
          if (!st.rrx) begin
            next_st.crx = 1'b1;
            next_st.act = lua_pkg::LUA_RX_ACT;
          end else begin
            next_st.act = lua_pkg::LUA_TX_ACT;
            next_st.tx  = lua_pkg::LUA_TX_DATA;
          end
        end
      end
      lua_pkg::LUA_RX_ACT: begin
        if (st.rrx) begin
          next_st.act = lua_pkg::LUA_FULL;
          next_st.tx  = lua_pkg::LUA_TX_DATA;
        end else if (st.act_exp) begin
          next_st.act = lua_pkg::LUA_FULL;
          next_st.tx  = lua_pkg::LUA_TX_DATA;
        end
      end
      lua_pkg::LUA_TX_ACT: begin
        // noise margin is always met, so sync alone readies us
        if (!st.swl || (i_sensitive_mode && st.act_exp && !st.swl))
          begin
          next_st.crx = 1'b1;
          next_st.act = lua_pkg::LUA_FULL;
        end else if (st.act_exp) begin
          next_st.act = lua_pkg::LUA_FULL;
        end
      end
      lua_pkg::LUA_FULL: begin
        if (i_quiet_command) begin
          next_st.act = lua_pkg::LUA_DEACT;
          next_st.tx  = lua_pkg::LUA_TX_SILENT;
          next_st.aux_t = SIGL_MS;
        end else if (st.swl) begin
          next_st.act   = lua_pkg::LUA_PEND;
          next_st.aux_t = PEND_MS;
        end
      end
      lua_pkg::LUA_PEND: begin
        if (!st.swl) begin
          next_st.act = lua_pkg::LUA_FULL;
        end else if (st.aux_t == '0) begin
          next_st.slt = 1'b1;
          next_st.act = lua_pkg::LUA_DEACT;
          next_st.tx  = lua_pkg::LUA_TX_SILENT;
          next_st.aux_t = SIGL_MS;
        end
      end
      lua_pkg::LUA_DEACT: begin
        next_st.tx = lua_pkg::LUA_TX_SILENT;
        // any return of signal restarts the 1 s window
        if (!i_signal_loss) begin
          next_st.aux_t = SIGL_MS;
        end else if (st.aux_t == '0) begin
          next_st.sgt = 1'b1;
          next_st.act = lua_pkg::LUA_INACTIVE;
        end
      end
      default: next_st = RST;
    endcase

    // central ready keeps its previous value while inactive, even on a new request
    if (st.act == lua_pkg::LUA_INACTIVE) next_st.crx = st.crx;
    if (i_srst) next_st = RST;
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign o_tx_mode             = st.tx;
  assign o_act_state           = st.act;
  assign o_sync_word_loss      = st.swl;
  assign o_central_rx_ready    = st.crx;
  assign o_remote_rx_ready     = st.rrx;
  assign o_sync_loss_timeout   = st.slt;
  assign o_signal_loss_timeout = st.sgt;
  // ready bit low is the ready indication, only when framed
  assign o_central_ready_bit   = !(st.crx && st.tx != lua_pkg::LUA_TX_SILENT
                                   && st.tx != lua_pkg::LUA_TX_INIT);

  // checks
  chk_deact_silent: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    st.act == lua_pkg::LUA_DEACT |=> st.tx == lua_pkg::LUA_TX_SILENT)
    else $error("transmitter not silent when deactivated");
  chk_req_starts: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (st.act == lua_pkg::LUA_INACTIVE && i_activation_request && !i_srst)
    |=> st.act == lua_pkg::LUA_ACTIVATE)
    else $error("request did not start activation");
  chk_quiet_exit: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (st.act == lua_pkg::LUA_FULL && i_quiet_command && !i_srst)
    |=> st.act == lua_pkg::LUA_DEACT)
    else $error("quiet did not deactivate");
  chk_loss_pend: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (st.act == lua_pkg::LUA_FULL && !i_quiet_command && st.swl && !i_srst)
    |=> st.act == lua_pkg::LUA_PEND)
    else $error("sync loss did not enter pending");
  chk_first_confirm: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (st.sync == lua_pkg::LUA_FIRST && i_frame_strobe && i_sync_word_hit
     && st.act != lua_pkg::LUA_DEACT && st.act != lua_pkg::LUA_INACTIVE
     && !i_srst) |=> (st.sync == lua_pkg::LUA_INS && !st.swl))
    else $error("second sync word did not lock");
  chk_miss_recover: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (st.sync == lua_pkg::LUA_MISS && i_frame_strobe && i_sync_word_hit
     && st.act != lua_pkg::LUA_DEACT && st.act != lua_pkg::LUA_INACTIVE
     && !i_srst) |=> st.sync == lua_pkg::LUA_INS)
    else $error("sync word in miss state not recovered");
  chk_miss_bound: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    st.sync == lua_pkg::LUA_MISS |-> (st.miss >= 3'h1 && st.miss <= MISS_TOP))
    else $error("miss count out of range");
  chk_swl_oos: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (st.sync == lua_pkg::LUA_OOS || st.sync == lua_pkg::LUA_FIRST) |-> st.swl)
    else $error("loss flag low while unsynchronised");
  chk_srst_clear: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    i_srst |=> (st.act == lua_pkg::LUA_INACTIVE && !st.crx && !st.rrx))
    else $error("reset did not clear");
endmodule
`default_nettype wire

// ---- bench/lua_remote_model.sv ----
// remote unit model: line power, frame slots and ready bits
`timescale 1ns/1ps
`default_nettype none
module lua_remote_model #(
  parameter int FRAME = 8 // cycles per frame slot
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_arst_n,
  // from the block and the bench
  input  wire logic [2:0] i_tx_mode,
  input  wire logic       i_hit_en,
  input  wire logic       i_rdy_bit,
  input  wire logic       i_line_dead,
  // toward the block
  output logic            o_remote_power,
  output logic            o_signal_loss,
  output logic            o_frame_strobe,
  output logic            o_sync_word_hit,
  output logic            o_overhead_valid,
  output logic            o_remote_ready_bit
);
  logic [7:0] cnt;    // frame slot counter
  logic       junk;   // toggles so idle lines never hold a stale value
  logic       framed; // our transmitter sends framed training or data
  assign framed = i_tx_mode[1] | i_tx_mode[2];
  // slot timing runs free; strobes only appear once frames exist
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt  <= 8'h00;
      junk <= 1'b0;
    end else begin
      cnt  <= (cnt == 8'(FRAME - 1)) ? 8'h00 : cnt + 8'h01;
      junk <= ~junk;
    end
  end
  assign o_frame_strobe     = framed && cnt == 8'h00;
  assign o_sync_word_hit    = o_frame_strobe ? i_hit_en : junk;
  assign o_overhead_valid   = o_frame_strobe;
  assign o_remote_ready_bit = o_overhead_valid ? i_rdy_bit : junk;
  // power simply mirrors what the bench says about the line
  assign o_remote_power = ~i_line_dead;
  assign o_signal_loss  = i_line_dead;
endmodule
`default_nettype wire

// ---- bench/lua_activation_tb_top.sv ----
// self-checking testbench for the activation block
`timescale 1ns/1ps
`default_nettype none
module lua_activation_tb_top;
  localparam int P    = 2; // cycles per ms, shortened so timers fit the run
  localparam int ECHO = lua_pkg::ECHO_TIME_MS * P;
  localparam int ACT  = lua_pkg::ACT_TIME_MS * P;
  localparam int SIGL = lua_pkg::SIGL_TIME_MS * P;
  logic        clk = 1'b0, arst_n = 1'b0, srst = 1'b0;
  logic        req = 1'b0, quiet = 1'b0, hit_en = 1'b0;
  logic        rdy = 1'b1, line_dead = 1'b1;
  logic        pwr, sigl, strobe, hit, ovh, rbit, crb;
  logic        swl, crx, rrx, swlt, siglt;
  logic [2:0]  tx;
  logic [6:0]  st;
  int          fail_count = 0, check_count = 0, n, k;
  logic [31:0] seed = 32'h00000057;
  always #2 clk = ~clk;
  // device under test
  lua_activation #(.PRESCALE(P)) dut (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_srst(srst),
    .i_activation_request(req), .i_quiet_command(quiet),
    .i_sensitive_mode(1'b0), .i_remote_power(pwr), .i_signal_loss(sigl),
    .i_frame_strobe(strobe), .i_sync_word_hit(hit),
    .i_overhead_valid(ovh), .i_remote_ready_bit(rbit),
    .o_tx_mode(tx), .o_central_ready_bit(crb), .o_act_state(st),
    .o_sync_word_loss(swl), .o_central_rx_ready(crx),
    .o_remote_rx_ready(rrx), .o_sync_loss_timeout(swlt),
    .o_signal_loss_timeout(siglt));
  // far end of the line
  lua_remote_model #(.FRAME(8)) remote (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_tx_mode(tx),
    .i_hit_en(hit_en), .i_rdy_bit(rdy), .i_line_dead(line_dead),
    .o_remote_power(pwr), .o_signal_loss(sigl), .o_frame_strobe(strobe),
    .o_sync_word_hit(hit), .o_overhead_valid(ovh),
    .o_remote_ready_bit(rbit));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_time(input string nm, input int got, lo, hi);
    check_count++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // bounded wait for the state (sel 0) or transmit mode (sel 1)
  task automatic wait_for(input int sel, input logic [6:0] exp,
                          input int max, output int cyc);
    cyc = 0;
    while ((sel == 0 ? st : 7'(tx)) !== exp) begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc > max) begin
        fail_count++;
        $display("wrong value wait %0d expected %h seen timeout", sel, exp);
        close_out();
      end
    end
  endtask
  // set what the remote sends, then let k frames pass the block
  task automatic frm(input logic h, r, input int k);
    int w;
    @(posedge clk);
    hit_en <= h;
    rdy    <= r;
    #1;
    repeat (k) begin
      w = 0;
      while (strobe !== 1'b1 && w < 40) begin
        @(posedge clk);
        #1;
        w++;
      end
      if (w >= 40) begin
        fail_count++;
        $display("wrong value frame strobe expected 1 seen timeout");
        close_out();
      end
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk("idle state", st, 7'h01);
    chk("reset outputs", {tx, swl, crx, rrx, crb}, 7'h09);
    $display("test reset done");
    // start-up up to fully active
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    #1;
    chk("activating", st, 7'h02);
    chk("tx initial", 7'(tx), 7'h01);
    repeat (200) @(posedge clk);
    line_dead <= 1'b0;
    wait_for(1, 7'h02, ECHO + 100, n);
    chk_time("echo hold", n, ECHO - 8, ECHO + 8);
    frm(1'b1, 1'b1, 1);
    chk("first word", 7'(swl), 7'h01);
    frm(1'b1, 1'b1, 1);
    chk("in sync", 7'(swl), 7'h00);
    @(posedge clk);
    #1;
    chk("rx active", {st, crx}, {7'h04, 1'b1});
    chk("ready bit", 7'(crb), 7'h00);
    frm(1'b1, 1'b0, 5);
    frm(1'b1, 1'b1, 1);
    chk("ready broken", 7'(rrx), 7'h00);
    frm(1'b1, 1'b0, 5);
    chk("ready five", 7'(rrx), 7'h00);
    frm(1'b1, 1'b0, 1);
    wait_for(0, 7'h10, 4, n);
    chk("full", {rrx, tx}, 4'hC);
    $display("test start-up done");
    // a random short miss run, then a real loss and regain
    seed = xs(seed);
    k = 1 + int'(seed % 5);
    frm(1'b0, 1'b0, k);
    frm(1'b1, 1'b0, 1);
    chk("miss recover", {st, swl}, {7'h10, 1'b0});
    frm(1'b0, 1'b0, 5);
    chk("five misses", 7'(swl), 7'h00);
    frm(1'b0, 1'b0, 1);
    chk("sixth miss", 7'(swl), 7'h01);
    wait_for(0, 7'h20, 4, n);
    frm(1'b1, 1'b0, 2);
    wait_for(0, 7'h10, 4, n);
    @(posedge clk);
    quiet <= 1'b1;
    wait_for(0, 7'h40, 4, n);
    chk("deact silent", 7'(tx), 7'h00);
    $display("test sync loss done");
    // short loss is ignored, a full second goes inactive
    @(posedge clk);
    quiet <= 1'b0;
    req   <= 1'b0;
    line_dead <= 1'b1;
    seed = xs(seed);
    repeat (100 + int'(seed % 1500)) @(posedge clk);
    line_dead <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk("short loss", st, 7'h40);
    @(posedge clk);
    line_dead <= 1'b1;
    wait_for(0, 7'h01, SIGL + 100, n);
    chk_time("loss window", n, SIGL - 8, SIGL + 8);
    chk("loss timeout", 7'(siglt), 7'h01);
    $display("test signal loss done");
    // restart, remote power late, never synchronised
    @(posedge clk);
    req <= 1'b1;
    wait_for(0, 7'h02, 4, n);
    // remote never sends a sync word this time
    hit_en <= 1'b0;
    repeat (1000) @(posedge clk);
    line_dead <= 1'b0;
    wait_for(0, 7'h40, ACT + 100, n);
    chk_time("act timer", n, ACT - 8, ACT + 8);
    chk("expired", {tx, swl}, 4'h1);
    $display("test expiry done");
    @(posedge clk);
    req  <= 1'b0;
    srst <= 1'b1;
    @(posedge clk);
    #1;
    chk("sync reset", {st, tx, swl, crx, rrx, crb},
        {7'h01, 7'h09});
    srst <= 1'b0;
    $display("test sync reset done");
    close_out();
  end
endmodule
`default_nettype wire
